// File: rioscs_pkg.sv
// shared constants, types and register map of the remote io slave block
package rioscs_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS       = 1000000;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_MS       = 1;
  localparam int FLASH_ON_MS   = 250;
  localparam int FLASH_OFF_MS  = 250;
  localparam int FLASH_GAP_MS  = 1000;
  localparam int FLASH_ON_TICKS  = FLASH_ON_MS / TICK_MS;
  localparam int FLASH_OFF_TICKS = FLASH_OFF_MS / TICK_MS;
  localparam int FLASH_GAP_TICKS = FLASH_GAP_MS / TICK_MS;
  localparam int CNT_W         = 16;

  localparam int SW_W          = 5;
  localparam int FB_W          = 32;
  localparam int ADDR_W        = 3;
  localparam int SW_ADDR_LSB   = 0;
  localparam int SW_MODE_A     = 3;
  localparam int SW_MODE_B     = 4;

  localparam logic [2:0] BYTES_NONE = 3'h0;
  localparam logic [2:0] BYTES_HALF = 3'h2;
  localparam logic [2:0] BYTES_FULL = 3'h4;

  localparam logic [3:0] DRV_FAULT_TYPE = 4'h4;
  localparam logic [3:0] DRV_FAULT_NUM  = 4'h1;

  localparam logic [4:0] REG_CONFIG  = 5'h00;
  localparam logic [4:0] REG_IMAGE   = 5'h04;
  localparam logic [4:0] REG_STATUS  = 5'h08;
  localparam logic [4:0] REG_MASK    = 5'h0c;
  localparam logic [4:0] REG_CODE    = 5'h10;
  localparam logic [4:0] REG_MONITOR = 5'h14;

  localparam int CFG_MODE_LSB  = 4;
  localparam int CFG_BYTES_LSB = 8;
  localparam int CODE_NUM_LSB  = 8;
  localparam int CODE_EN_BIT   = 16;
  localparam int ST_W          = 3;
  localparam int ST_TIMEOUT    = 0;
  localparam int ST_DRV_LOST   = 1;
  localparam int ST_BUS_UP     = 2;

  localparam logic [CNT_W-1:0] MONITOR_RST = 16'h0064;
  localparam logic [31:0]      CODE_RST    = 32'h0000_0000;

  typedef enum logic [3:0] {
    MODE_NONE    = 4'h1,
    MODE_NORMAL  = 4'h2,
    MODE_SHIFTED = 4'h4,
    MODE_HALVED  = 4'h8
  } rioscs_mode_t;

  typedef enum logic [3:0] {
    FL_IDLE = 4'h1,
    FL_ON   = 4'h2,
    FL_OFF  = 4'h4,
    FL_GAP  = 4'h8
  } rioscs_flash_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    rioscs_mode_t      mode;
  } rioscs_cfg_t;

  typedef struct packed {
    logic bus_ok_led;
    logic bus_fault_led;
    logic failure_select_led;
    logic failure_number_led;
    logic logic_supply_ok_led;
    logic driver_supply_ok_led;
  } rioscs_leds_t;

endpackage

// File: rioscs_flash.sv
// flash-pulse generator for the failure select and failure number leds
`timescale 1ns/1ps
`default_nettype none
module rioscs_flash (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       tick,
  input  wire logic       en,
  input  wire logic [3:0] code_type,
  input  wire logic [3:0] code_num,
  output logic            sel_led,
  output logic            num_led
);

  rioscs_pkg::rioscs_flash_t             state_q;
  logic                                  phase_q;
  logic [3:0]                            pulses_q;
  logic [rioscs_pkg::CNT_W-1:0]          cnt_q;

  // an empty group goes straight to the pause
  function automatic rioscs_pkg::rioscs_flash_t first_state(
    input logic [3:0] count
  );
    first_state = (count == 4'h0) ? rioscs_pkg::FL_GAP : rioscs_pkg::FL_ON;
  endfunction

  always_ff @(posedge clk) begin
    if (reset || !en) begin
      state_q  <= rioscs_pkg::FL_IDLE;
      phase_q  <= 1'b0;
      pulses_q <= 4'h0;
      cnt_q    <= '0;
    end else begin
      case (state_q)
        rioscs_pkg::FL_IDLE: begin
          phase_q  <= 1'b0;
          pulses_q <= code_type;
          cnt_q    <= '0;
          state_q  <= first_state(code_type);
        end
        rioscs_pkg::FL_ON: begin
          if (tick) begin
            if (cnt_q == rioscs_pkg::CNT_W'(rioscs_pkg::FLASH_ON_TICKS - 1)) begin
              cnt_q    <= '0;
              pulses_q <= pulses_q - 4'h1;
              state_q  <= rioscs_pkg::FL_OFF;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        rioscs_pkg::FL_OFF: begin
          if (tick) begin
            if (cnt_q == rioscs_pkg::CNT_W'(rioscs_pkg::FLASH_OFF_TICKS - 1)) begin
              cnt_q   <= '0;
              state_q <= (pulses_q == 4'h0) ? rioscs_pkg::FL_GAP
                                            : rioscs_pkg::FL_ON;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        rioscs_pkg::FL_GAP: begin
          if (tick) begin
            if (cnt_q == rioscs_pkg::CNT_W'(rioscs_pkg::FLASH_GAP_TICKS - 1)) begin
              // alternate type group and number group forever
              cnt_q    <= '0;
              phase_q  <= ~phase_q;
              pulses_q <= phase_q ? code_type : code_num;
              state_q  <= first_state(phase_q ? code_type : code_num);
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
        end
        default: begin
          state_q <= rioscs_pkg::FL_IDLE;
        end
      endcase
    end
  end

  assign sel_led = (state_q != rioscs_pkg::FL_IDLE) && !phase_q;
  assign num_led = (state_q == rioscs_pkg::FL_ON);

  property p_gap_dark;
    @(posedge clk) disable iff (reset)
      en && (state_q == rioscs_pkg::FL_GAP) && !tick |=>
        !num_led && (cnt_q == $past(cnt_q));
  endproperty
  a_gap_dark: assert property (p_gap_dark)
    else $error("pause not dark or counter moved without tick");

  property p_sel_phase;
    @(posedge clk) disable iff (reset)
      !reset && en && (state_q == rioscs_pkg::FL_IDLE) |=> sel_led;
  endproperty
  a_sel_phase: assert property (p_sel_phase)
    else $error("select led does not follow group kind");

endmodule
`default_nettype wire

// File: rioscs_top.sv
// config latch, input image packing, status leds and avalon registers
//
// Function
// - station address is switches 1 to 3, switch 1 least significant, 0 to 7
// - switches are taken only at reset, later changes wait for next reset
// - switches 4,5: off/off none, 4 normal, 5 shifted, both halved
// - normal mode puts inputs in order, right to left, into the image
// - shifted mode alternates inputs 1-16 over bytes 0,1 and 17-32 over 2,3
// - halved mode sends only odd inputs, 32 inputs fill 2 bytes
// - green bus ok led lit while internal bus communication is active
// - fault free: bus ok on, fault off, select and number off, supplies on
// - monitor timeout: bus ok off, bus fault flashes, select and number off
// - select led lit means number led shows type, dark means number
// - type or number is shown as a count of flash pulses
// - logic supply led lit while logic, input and bus supply is present
// - driver supply led lit while output supply is present
// - output supply missing: driver led off, flash type 4 then number 1
`timescale 1ns/1ps
`default_nettype none
module rioscs_top #(
  parameter int unsigned TICK_CYCLES = rioscs_pkg::TICK_CYCLES
) (
  input  wire logic                            clk,
  input  wire logic                            reset,
  input  wire logic [rioscs_pkg::SW_W-1:0]     dip_switch,
  input  wire logic [rioscs_pkg::FB_W-1:0]     feedback_in,
  input  wire logic                            logic_supply_ok,
  input  wire logic                            driver_supply_ok,
  input  wire logic                            bus_activity,
  output logic [rioscs_pkg::ADDR_W-1:0]        station_addr,
  output logic [rioscs_pkg::FB_W-1:0]          input_process_image,
  output logic [2:0]                           image_bytes,
  output rioscs_pkg::rioscs_leds_t             leds,
  input  wire logic [4:0]                      avs_address,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [31:0]                     avs_writedata,
  input  wire logic [3:0]                      avs_byteenable,
  output logic [31:0]                          avs_readdata,
  output logic                                 avs_waitrequest,
  output logic                                 irq
);

  logic [rioscs_pkg::SW_W-1:0]   sw_meta_q;
  logic [rioscs_pkg::SW_W-1:0]   sw_sync_q;
  logic [rioscs_pkg::FB_W-1:0]   fb_meta_q;
  logic [rioscs_pkg::FB_W-1:0]   fb_sync_q;
  logic [1:0]                    sup_meta_q;
  logic [1:0]                    sup_sync_q;
  rioscs_pkg::rioscs_cfg_t       cfg_q;
  logic [rioscs_pkg::FB_W-1:0]   shifted_img;
  logic [rioscs_pkg::FB_W-1:0]   halved_img;
  logic [rioscs_pkg::FB_W-1:0]   image_q;
  logic [2:0]                    bytes_q;
  logic [31:0]                   tick_cnt_q;
  logic                          tick;
  logic [rioscs_pkg::CNT_W-1:0]  mon_cnt_q;
  logic [rioscs_pkg::CNT_W-1:0]  monitor_q;
  logic                          active_q;
  logic                          timeout_q;
  logic [rioscs_pkg::CNT_W-1:0]  blink_cnt_q;
  logic                          blink_q;
  logic                          drv_ok_d1_q;
  logic [rioscs_pkg::ST_W-1:0]   status_q;
  logic [rioscs_pkg::ST_W-1:0]   mask_q;
  logic [rioscs_pkg::ST_W-1:0]   events;
  logic [rioscs_pkg::ST_W-1:0]   clear_bits;
  logic [31:0]                   code_q;
  logic                          ack_q;
  logic                          wr_go;
  logic [31:0]                   readdata_q;
  logic                          flash_en;
  logic [3:0]                    flash_type;
  logic [3:0]                    flash_num;
  logic                          flash_sel;
  logic                          flash_num_led;
  rioscs_pkg::rioscs_leds_t      leds_q;

  // two-stage synchronisers for switch, input and supply pins; bus_activity, reset and avalon pins are not synchronised
  always_ff @(posedge clk) begin
    sw_meta_q  <= dip_switch;
    sw_sync_q  <= sw_meta_q;
    fb_meta_q  <= feedback_in;
    fb_sync_q  <= fb_meta_q;
    sup_meta_q <= {driver_supply_ok, logic_supply_ok};
    sup_sync_q <= sup_meta_q;
  end

  function automatic rioscs_pkg::rioscs_cfg_t decode_cfg(
    input logic [rioscs_pkg::SW_W-1:0] sw
  );
    rioscs_pkg::rioscs_cfg_t c;
    c.addr = sw[rioscs_pkg::SW_ADDR_LSB +: rioscs_pkg::ADDR_W];
    case ({sw[rioscs_pkg::SW_MODE_B], sw[rioscs_pkg::SW_MODE_A]})
      2'b01:   c.mode = rioscs_pkg::MODE_NORMAL;
      2'b10:   c.mode = rioscs_pkg::MODE_SHIFTED;
      2'b11:   c.mode = rioscs_pkg::MODE_HALVED;
      default: c.mode = rioscs_pkg::MODE_NONE;
    endcase
    decode_cfg = c;
  endfunction

  // switches copied only while reset is held
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_q <= decode_cfg(sw_sync_q);
    end
  end

  assign station_addr = cfg_q.addr;

  // input j of a group of 16 goes to even or odd byte by its parity
  genvar j;
  generate
    for (j = 0; j < 8; j++) begin : g_pack
      assign shifted_img[j]      = fb_sync_q[2*j];
      assign shifted_img[8+j]    = fb_sync_q[2*j+1];
      assign shifted_img[16+j]   = fb_sync_q[16+2*j];
      assign shifted_img[24+j]   = fb_sync_q[17+2*j];
      assign halved_img[j]       = fb_sync_q[2*j];
      assign halved_img[8+j]     = fb_sync_q[16+2*j];
      assign halved_img[16+j]    = 1'b0;
      assign halved_img[24+j]    = 1'b0;
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      image_q <= '0;
      bytes_q <= rioscs_pkg::BYTES_NONE;
    end else begin
      case (cfg_q.mode)
        rioscs_pkg::MODE_NORMAL: begin
          image_q <= fb_sync_q;
          bytes_q <= rioscs_pkg::BYTES_FULL;
        end
        rioscs_pkg::MODE_SHIFTED: begin
          image_q <= shifted_img;
          bytes_q <= rioscs_pkg::BYTES_FULL;
        end
        rioscs_pkg::MODE_HALVED: begin
          image_q <= halved_img;
          bytes_q <= rioscs_pkg::BYTES_HALF;
        end
        default: begin
          image_q <= '0;
          bytes_q <= rioscs_pkg::BYTES_NONE;
        end
      endcase
    end
  end

  assign input_process_image = image_q;
  assign image_bytes         = bytes_q;

  // millisecond tick enable
  always_ff @(posedge clk) begin
    if (reset || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end
  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

  // signal monitoring of the main terminal's activations
  always_ff @(posedge clk) begin
    if (reset) begin
      mon_cnt_q <= '0;
      active_q  <= 1'b0;
      timeout_q <= 1'b0;
    end else if (bus_activity) begin
      mon_cnt_q <= '0;
      active_q  <= 1'b1;
      timeout_q <= 1'b0;
    end else if (tick && !timeout_q) begin
      if (mon_cnt_q + 1'b1 >= monitor_q) begin
        active_q  <= 1'b0;
        timeout_q <= 1'b1;
      end else begin
        mon_cnt_q <= mon_cnt_q + 1'b1;
      end
    end
  end

  // bus fault blink, half period equals one flash pulse
  always_ff @(posedge clk) begin
    if (reset || !timeout_q) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b1;
    end else if (tick) begin
      if (blink_cnt_q == rioscs_pkg::CNT_W'(rioscs_pkg::FLASH_ON_TICKS - 1)) begin
        blink_cnt_q <= '0;
        blink_q     <= ~blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 1'b1;
      end
    end
  end

  // what the flash code shows: bus fault keeps it dark
  always_comb begin
    flash_en   = 1'b0;
    flash_type = 4'h0;
    flash_num  = 4'h0;
    if (timeout_q) begin
      flash_en = 1'b0;
    end else if (!sup_sync_q[1]) begin
      flash_en   = 1'b1;
      flash_type = rioscs_pkg::DRV_FAULT_TYPE;
      flash_num  = rioscs_pkg::DRV_FAULT_NUM;
    end else if (code_q[rioscs_pkg::CODE_EN_BIT]) begin
      flash_en   = 1'b1;
      flash_type = code_q[3:0];
      flash_num  = code_q[rioscs_pkg::CODE_NUM_LSB +: 4];
    end
  end

  rioscs_flash u_flash (
    .clk       (clk),
    .reset     (reset),
    .tick      (tick),
    .en        (flash_en),
    .code_type (flash_type),
    .code_num  (flash_num),
    .sel_led   (flash_sel),
    .num_led   (flash_num_led)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      leds_q <= '0;
    end else begin
      leds_q.bus_ok_led           <= active_q;
      leds_q.bus_fault_led        <= timeout_q && blink_q;
      leds_q.failure_select_led   <= flash_sel;
      leds_q.failure_number_led   <= flash_num_led;
      leds_q.logic_supply_ok_led  <= sup_sync_q[0];
      leds_q.driver_supply_ok_led <= sup_sync_q[1];
    end
  end
  assign leds = leds_q;

  // interrupt events
  always_ff @(posedge clk) begin
    if (reset) begin
      drv_ok_d1_q <= 1'b1;
    end else begin
      drv_ok_d1_q <= sup_sync_q[1];
    end
  end

  always_comb begin
    events = '0;
    events[rioscs_pkg::ST_TIMEOUT]  = tick && !timeout_q && !bus_activity &&
                                      (mon_cnt_q + 1'b1 >= monitor_q);
    events[rioscs_pkg::ST_DRV_LOST] = drv_ok_d1_q && !sup_sync_q[1];
    events[rioscs_pkg::ST_BUS_UP]   = bus_activity && !active_q;
  end

  // avalon slave: one wait state on every access
  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wdata[8*b +: 8];
      end
    end
    be_merge = r;
  endfunction

  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign wr_go           = avs_write && ack_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  assign clear_bits = (wr_go && avs_address == rioscs_pkg::REG_STATUS) ?
    rioscs_pkg::ST_W'(be_merge(32'h0, avs_writedata, avs_byteenable)) :
    '0;

  always_ff @(posedge clk) begin
    if (reset) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clear_bits) | events;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_q    <= '0;
      code_q    <= rioscs_pkg::CODE_RST;
      monitor_q <= rioscs_pkg::MONITOR_RST;
    end else if (wr_go) begin
      case (avs_address)
        rioscs_pkg::REG_MASK:
          mask_q <= rioscs_pkg::ST_W'(be_merge(32'(mask_q), avs_writedata,
                                               avs_byteenable));
        rioscs_pkg::REG_CODE:
          code_q <= be_merge(code_q, avs_writedata, avs_byteenable);
        rioscs_pkg::REG_MONITOR:
          monitor_q <= rioscs_pkg::CNT_W'(
            be_merge(32'(monitor_q), avs_writedata, avs_byteenable));
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      readdata_q <= '0;
    end else if (avs_read && !ack_q) begin
      case (avs_address)
        rioscs_pkg::REG_CONFIG:
          readdata_q <= {21'h0, bytes_q, cfg_q.mode, 1'b0, cfg_q.addr};
        rioscs_pkg::REG_IMAGE:   readdata_q <= image_q;
        rioscs_pkg::REG_STATUS:  readdata_q <= 32'(status_q);
        rioscs_pkg::REG_MASK:    readdata_q <= 32'(mask_q);
        rioscs_pkg::REG_CODE:    readdata_q <= code_q;
        rioscs_pkg::REG_MONITOR: readdata_q <= 32'(monitor_q);
        default:                 readdata_q <= 32'h0;
      endcase
    end
  end
  assign avs_readdata = readdata_q;
  assign irq          = |(status_q & mask_q);

  property p_cfg_hold;
    @(posedge clk) disable iff (reset)
      1'b1 |=> $stable(cfg_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("configuration changed outside reset");

  property p_addr_from_sw;
    @(posedge clk) disable iff (reset)
      $fell(reset) |-> station_addr == $past(sw_sync_q[2:0]);
  endproperty
  a_addr_from_sw: assert property (p_addr_from_sw)
    else $error("station address not taken from switches 1 to 3");

  property p_mode_decode;
    @(posedge clk) disable iff (reset)
      $fell(reset) |->
        ((cfg_q.mode == rioscs_pkg::MODE_SHIFTED) ==
         ($past(sw_sync_q[4]) && !$past(sw_sync_q[3])));
  endproperty
  a_mode_decode: assert property (p_mode_decode)
    else $error("shifted mode decoded from wrong switches");

  property p_normal;
    @(posedge clk) disable iff (reset)
      !reset && (cfg_q.mode == rioscs_pkg::MODE_NORMAL) |=>
        image_q == $past(fb_sync_q) && bytes_q == 3'h4;
  endproperty
  a_normal: assert property (p_normal)
    else $error("normal image not in order");

  property p_shifted;
    @(posedge clk) disable iff (reset)
      !reset && (cfg_q.mode == rioscs_pkg::MODE_SHIFTED) |=>
        image_q[8] == $past(fb_sync_q[1]) &&
        image_q[17] == $past(fb_sync_q[18]);
  endproperty
  a_shifted: assert property (p_shifted)
    else $error("shifted image misplaced");

  property p_halved;
    @(posedge clk) disable iff (reset)
      !reset && (cfg_q.mode == rioscs_pkg::MODE_HALVED) |=>
        image_q[1] == $past(fb_sync_q[2]) && bytes_q == 3'h2 &&
        image_q[31:16] == 16'h0;
  endproperty
  a_halved: assert property (p_halved)
    else $error("halved image wrong");

  property p_none;
    @(posedge clk) disable iff (reset)
      cfg_q.mode == rioscs_pkg::MODE_NONE |=> bytes_q == 3'h0;
  endproperty
  a_none: assert property (p_none)
    else $error("bytes reported with no inputs");

  property p_timeout_leds;
    @(posedge clk) disable iff (reset)
      timeout_q && !bus_activity |=> ##1 !leds.bus_ok_led &&
        !leds.failure_select_led && !leds.failure_number_led;
  endproperty
  a_timeout_leds: assert property (p_timeout_leds)
    else $error("leds wrong after monitor timeout");

  property p_drv_code;
    @(posedge clk) disable iff (reset)
      !timeout_q && !sup_sync_q[1] |->
        (flash_en && flash_type == 4'h4 && flash_num == 4'h1) ##1
        !leds.driver_supply_ok_led;
  endproperty
  a_drv_code: assert property (p_drv_code)
    else $error("missing output supply not flashed as 4 then 1");

  property p_wait_one;
    @(posedge clk) disable iff (reset)
      (avs_read || avs_write) && !ack_q |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("access not answered after one wait state");

endmodule
`default_nettype wire

// File: rioscs_term_model.sv
// main terminal model: periodic activation pulses on the internal bus
`timescale 1ns/1ps
`default_nettype none
module rioscs_term_model #(
  parameter int PERIOD = 8
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic enable,
  output logic      bus_activity
);
  int cnt_q;
  // one pulse per period while this slave is being served
  always_ff @(posedge clk) begin
    if (reset || !enable) begin
      cnt_q        <= 0;
      bus_activity <= 1'b0;
    end else begin
      cnt_q        <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      bus_activity <= (cnt_q == PERIOD - 1);
    end
  end
endmodule
`default_nettype wire

// File: rioscs_top_tb.sv
// self-checking bench of the remote io slave block
`timescale 1ns/1ps
`default_nettype none
module rioscs_top_tb;
  logic clk = 1'b0, reset = 1'b1, ls_ok = 1'b1, drv_ok = 1'b1, t_en = 1'b0;
  logic [4:0]  dip = 5'h00, adr = 5'h00;
  logic [31:0] fb = 32'h0, wd = 32'h0, rd, rdata, image;
  logic        rdq = 1'b0, wrq = 1'b0, wreq, irq, bus_act;
  logic [2:0]  st_addr, nbytes;
  rioscs_pkg::rioscs_leds_t leds;
  int err_count = 0, n_tests = 0;
  always #2 clk = ~clk;

  rioscs_top #(.TICK_CYCLES(4)) dut (.clk(clk), .reset(reset),
    .dip_switch(dip), .feedback_in(fb), .logic_supply_ok(ls_ok),
    .driver_supply_ok(drv_ok), .bus_activity(bus_act),
    .station_addr(st_addr), .input_process_image(image),
    .image_bytes(nbytes), .leds(leds), .avs_address(adr), .avs_read(rdq),
    .avs_write(wrq), .avs_writedata(wd), .avs_byteenable(4'hf),
    .avs_readdata(rd), .avs_waitrequest(wreq), .irq(irq));
  rioscs_term_model #(.PERIOD(8)) term (.clk(clk), .reset(reset),
    .enable(t_en), .bus_activity(bus_act));

  task automatic results();
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tmo();
    err_count++;
    $display("Error at %0t: wait timed out", $time);
    results();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    rdq <= !w; wrq <= w; adr <= a; wd <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    rdata = rd;
    rdq <= 1'b0; wrq <= 1'b0;
    if (i == 50) tmo();
  endtask
  task automatic wait_led(input int b, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && leds[b] !== v; i++) @(posedge clk);
    if (i == lim) tmo();
  endtask
  task automatic count_pulses(input logic s, input int lim, output int cnt);
    int i;
    logic p;
    cnt = 0;
    p = 1'b0;
    for (i = 0; i < lim && leds.failure_select_led === s; i++) begin
      @(posedge clk);
      if (leds.failure_select_led === s && leds.failure_number_led && !p) cnt++;
      p = leds.failure_number_led;
    end
    if (i == lim) tmo();
  endtask
  task automatic restart(input logic [4:0] d);
    @(posedge clk);
    dip <= d; reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  function automatic logic [31:0] pack(input logic [1:0] m,
                                       input logic [31:0] f);
    logic [31:0] e;
    e = (m == 2'h1) ? f : 32'h0;
    for (int k = 0; k < 32; k++) begin
      if (m == 2'h2) e[(k/16)*16 + (k%2)*8 + (k%16)/2] = f[k];
      if (m == 2'h3 && k < 16) e[k] = f[2*k];
    end
    return e;
  endfunction

  task automatic t_modes();
    logic [4:0] d;
    for (int n = 0; n < 4; n++) begin
      d = (n == 0) ? 5'h0d : (n == 1) ? 5'h12 : (n == 2) ? 5'h1f : 5'h00;
      restart(d);
      fb <= 32'h9c3a_65e1 ^ {8{n[3:0]}};
      dip <= ~d;
      repeat (8) @(posedge clk);
      chk(st_addr, d[2:0]);
      chk(nbytes, d[4:3] == 2'h0 ? 3'h0 :
                  d[4:3] == 2'h3 ? 3'h2 : 3'h4);
      chk(image, pack(d[4:3], fb));
    end
  endtask
  task automatic t_bus();
    t_en <= 1'b1;
    wait_led(5, 1'b1, 200);
    bus(1'b1, 5'h14, 32'h0000_0005);
    bus(1'b0, 5'h14, 32'h0);
    chk(rdata, 32'h0000_0005);
    bus(1'b1, 5'h08, 32'h0000_0007);
    bus(1'b1, 5'h0c, 32'h0000_0001);
    @(posedge clk);
    chk(irq, 1'b0);
    chk(leds, 6'h23);
    t_en <= 1'b0;
    wait_led(5, 1'b0, 100);
    @(posedge clk);
    chk(irq, 1'b1);
    chk(leds[3:2], 2'h0);
    wait_led(4, 1'b0, 1200);
    wait_led(4, 1'b1, 1200);
    bus(1'b1, 5'h0c, 32'h0);
    @(posedge clk);
    chk(irq, 1'b0);
    bus(1'b1, 5'h0c, 32'h0000_0001);
    bus(1'b1, 5'h08, 32'h0000_0001);
    @(posedge clk);
    chk(irq, 1'b0);
    bus(1'b0, 5'h1c, 32'h0);
    chk(rdata, 32'h0);
  endtask
  task automatic t_supply();
    int cnt;
    t_en <= 1'b1;
    wait_led(5, 1'b1, 200);
    ls_ok <= 1'b0;
    wait_led(1, 1'b0, 20);
    ls_ok <= 1'b1;
    drv_ok <= 1'b0;
    wait_led(0, 1'b0, 20);
    wait_led(3, 1'b1, 100);
    count_pulses(1'b1, 13000, cnt);
    chk(cnt, 4);
    count_pulses(1'b0, 6500, cnt);
    chk(cnt, 1);
    drv_ok <= 1'b1;
    wait_led(3, 1'b0, 20);
    bus(1'b1, 5'h10, 32'h0001_0302);
    wait_led(3, 1'b1, 100);
    count_pulses(1'b1, 10000, cnt);
    chk(cnt, 2);
  endtask

  initial begin
    t_modes();
    t_bus();
    t_supply();
    results();
  end
endmodule
`default_nettype wire
